/* design/monitor_config_and_shunt_result.sv */
// configuration register, conversion sequencer and shunt result of the monitor
//
// Behaviour
// - bit 15 write acts as power-on reset
// - bit 13 picks 16 V or 32 V
// - bits 12:11 pick the shunt gain range
// - bits 10:7 hold bus converter setting
// - bits 6:3 hold shunt converter setting
// - top bit zero: 9 to 12 bits
// - top bit one: 12 bits or averaging
// - bits 2:0 select the operating mode
// - reset mode is continuous shunt and bus
// - configuration at 00h, resets to 399Fh
// - shunt reading read-only at 01h
// - negative readings in two's complement
// - all sign bits carry one value
// - 10 uV step, gain-dependent full scale
// - one to four sign bits per gain
// - registers move as two bytes, MSB first
`timescale 1ns/1ps
`include "monitor_consts.svh"

module monitor_config_and_shunt_result
   import monitor_pkg::*;
#(
   // conversion lengths in clock cycles, one per time code
   parameter int unsigned CONV_CYCLES [`CONV_TIME_COUNT] = '{
      `T_9BIT_NS / `CLK_PERIOD_NS, `T_10BIT_NS / `CLK_PERIOD_NS,
      `T_11BIT_NS / `CLK_PERIOD_NS, `T_12BIT_NS / `CLK_PERIOD_NS,
      `T_12BIT_NS / `CLK_PERIOD_NS, `T_AVG2_NS / `CLK_PERIOD_NS,
      `T_AVG4_NS / `CLK_PERIOD_NS, `T_AVG8_NS / `CLK_PERIOD_NS,
      `T_AVG16_NS / `CLK_PERIOD_NS, `T_AVG32_NS / `CLK_PERIOD_NS,
      `T_AVG64_NS / `CLK_PERIOD_NS, `T_AVG128_NS / `CLK_PERIOD_NS},
   parameter int unsigned COUNT_W = 23
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire host_request_s HOST_REQ_I,
   input wire logic signed [15:0] SHUNT_SAMPLE_I,
   output logic [7:0] RD_BYTE_O,
   output logic RD_VALID_O,
   output logic SHUNT_CONV_O,
   output logic BUS_CONV_O,
   output logic BUS_RANGE_O,
   output logic [3:0] BUS_SETTING_O,
   output logic CONV_DONE_O,
   output logic [15:0] SHUNT_RESULT_O
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   measurement_configuration_s cfg; // configuration register
   measurement_configuration_s next_cfg;
   logic [7:0] pointer; // register pointer
   logic [7:0] next_pointer;
   logic msb_phase; // 1 while next data byte is the high byte
   logic next_msb_phase;
   logic [7:0] held_msb; // high byte of a write in flight
   logic [7:0] next_held_msb;
   logic [7:0] rd_byte;
   logic [7:0] next_rd_byte;
   logic rd_valid;
   logic next_rd_valid;
   logic cfg_write; // full word written to the configuration
   logic soft_reset; // software asked for a power-on reset
   logic [15:0] write_word; // assembled write word
   logic [15:0] read_word; // word selected by the pointer
   conv_state_e state; // converter sequencer state
   conv_state_e next_state;
   logic [COUNT_W-1:0] count; // cycles left in this conversion
   logic [COUNT_W-1:0] next_count;
   logic trig_pending; // triggered conversion requested
   logic next_trig_pending;
   logic [2:0] run_mode; // mode latched at sequence start
   logic [2:0] next_run_mode;
   logic [1:0] run_gain; // gain latched at conversion start
   logic [1:0] next_run_gain;
   logic run_range; // bus range latched at conversion start
   logic next_run_range;
   logic [3:0] run_bus_set; // bus setting latched at conversion start
   logic [3:0] next_run_bus_set;
   logic [15:0] shunt_result; // formatted shunt reading
   logic [15:0] next_shunt_result;
   logic done; // one-cycle pulse at sequence end
   logic next_done;
   logic [15:0] formatted; // clamped sample for the latched gain
   logic conv_end; // current conversion finishes this cycle

   // length of a conversion for a four-bit converter setting
   function automatic logic [COUNT_W-1:0] conv_len(input logic [3:0] setting);
      logic [3:0] idx;
      idx = 4'h0;
      if (setting[`SET_AVG_BIT]) begin
         idx = `SET_AVG_BASE + {1'b0, setting[`SET_AVG_CODE_W-1:0]};
      end else begin
         idx = {2'b00, setting[`SET_RES_CODE_W-1:0]};
      end
      conv_len = COUNT_W'(CONV_CYCLES[idx] - 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // host byte interface

   assign write_word = {held_msb, HOST_REQ_I.data};
   assign cfg_write = HOST_REQ_I.data_write && !HOST_REQ_I.frame_start && !HOST_REQ_I.pointer_write
      && !msb_phase && (pointer == `CFG_ADDR);
   assign soft_reset = cfg_write && write_word[`CFG_SOFT_RESET_BIT];

   // select the word that the pointer names; others read as zero
   always_comb begin
      case (pointer)
         `CFG_ADDR: read_word = cfg;
         `SHUNT_ADDR: read_word = shunt_result;
         default: read_word = 16'h0000;
      endcase
   end

   // pointer, byte phase and read byte
   always_comb begin
      next_pointer = pointer;
      next_msb_phase = msb_phase;
      next_held_msb = held_msb;
      next_rd_byte = rd_byte;
      next_rd_valid = 1'b0;
      if (HOST_REQ_I.frame_start) begin
         // every frame starts on the high byte
         next_msb_phase = 1'b1;
      end else if (HOST_REQ_I.pointer_write) begin
         next_pointer = HOST_REQ_I.data;
         next_msb_phase = 1'b1;
      end else if (HOST_REQ_I.data_write) begin
         // high byte is held, low byte commits the word
         if (msb_phase) begin
            next_held_msb = HOST_REQ_I.data;
         end
         next_msb_phase = !msb_phase;
      end else if (HOST_REQ_I.read_byte) begin
         // high byte first, then low byte
         next_rd_byte = msb_phase ? read_word[15:8] : read_word[7:0];
         next_rd_valid = 1'b1;
         next_msb_phase = !msb_phase;
      end
   end

   // register the host interface state
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pointer <= `CFG_ADDR;
         msb_phase <= 1'b1;
         held_msb <= 8'h00;
         rd_byte <= 8'h00;
         rd_valid <= 1'b0;
      end else if (CE_I) begin
         pointer <= next_pointer;
         msb_phase <= next_msb_phase;
         held_msb <= next_held_msb;
         rd_byte <= next_rd_byte;
         rd_valid <= next_rd_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration register

   // soft reset restores defaults; the reset bit itself never sticks
   always_comb begin
      next_cfg = cfg;
      if (soft_reset) begin
         next_cfg = `CFG_RESET;
      end else if (cfg_write) begin
         // bit 14 is stored as written, bit 15 self-clears
         next_cfg = write_word;
         next_cfg.soft_reset = 1'b0;
      end
   end

   // register the configuration
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg <= `CFG_RESET;
      end else if (CE_I) begin
         cfg <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer

   assign conv_end = (state != CONV_IDLE) && (count == '0);

   // clamp the sample to the full scale of the latched gain
   shunt_formatter #(
      .WIDTH(16)
   ) u_shunt_formatter (
      .shunt_gain_select_i(run_gain),
      .raw_sample_i(SHUNT_SAMPLE_I),
      .result_o(formatted)
   );

   // start, step and end conversions; settings latch only at a start
   always_comb begin
      next_state = state;
      next_count = count;
      next_trig_pending = trig_pending;
      next_run_mode = run_mode;
      next_run_gain = run_gain;
      next_run_range = run_range;
      next_run_bus_set = run_bus_set;
      next_shunt_result = shunt_result;
      next_done = 1'b0;
      case (state)
         CONV_IDLE: begin
            if (trig_pending || (cfg.mode[`CFG_MODE_CONT_BIT] && cfg.mode[1:0] != 2'h0)) begin
               next_run_mode = cfg.mode;
               next_run_gain = cfg.shunt_gain_select;
               next_run_range = cfg.bus_range_select;
               next_run_bus_set = cfg.bus_conversion_setting;
               next_trig_pending = 1'b0;
               if (cfg.mode[`CFG_MODE_SHUNT_BIT]) begin
                  next_state = CONV_SHUNT;
                  next_count = conv_len(cfg.shunt_conversion_setting);
               end else begin
                  next_state = CONV_BUS;
                  next_count = conv_len(cfg.bus_conversion_setting);
               end
            end
         end
         CONV_SHUNT: begin
            if (conv_end) begin
               next_shunt_result = formatted;
               if (run_mode[`CFG_MODE_BUS_BIT]) begin
                  // bus follows the shunt, on fresh bus settings
                  next_state = CONV_BUS;
                  next_count = conv_len(cfg.bus_conversion_setting);
                  next_run_range = cfg.bus_range_select;
                  next_run_bus_set = cfg.bus_conversion_setting;
               end else begin
                  next_state = CONV_IDLE;
                  next_done = 1'b1;
               end
            end else begin
               next_count = count - 1'b1;
            end
         end
         CONV_BUS: begin
            if (conv_end) begin
               next_state = CONV_IDLE;
               next_done = 1'b1;
            end else begin
               next_count = count - 1'b1;
            end
         end
         default: begin
            next_state = CONV_IDLE;
         end
      endcase
      if (cfg_write && !soft_reset) begin
         // a write of a triggered mode arms one sequence; after the start so it is never lost
         next_trig_pending = !next_cfg.mode[`CFG_MODE_CONT_BIT] && (next_cfg.mode != 3'h0);
      end
      if (soft_reset) begin
         // power-on state again; a conversion in flight is dropped
         next_state = CONV_IDLE;
         next_count = '0;
         next_trig_pending = 1'b0;
         next_shunt_result = 16'h0000;
         next_done = 1'b0;
      end
   end

   // register the sequencer
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state <= CONV_IDLE;
         count <= '0;
         trig_pending <= 1'b0;
         run_mode <= 3'h0;
         run_gain <= 2'h0;
         run_range <= 1'b0;
         run_bus_set <= 4'h0;
         shunt_result <= 16'h0000;
         done <= 1'b0;
      end else if (CE_I) begin
         state <= next_state;
         count <= next_count;
         trig_pending <= next_trig_pending;
         run_mode <= next_run_mode;
         run_gain <= next_run_gain;
         run_range <= next_run_range;
         run_bus_set <= next_run_bus_set;
         shunt_result <= next_shunt_result;
         done <= next_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign RD_BYTE_O = rd_byte;
   assign RD_VALID_O = rd_valid;
   assign SHUNT_CONV_O = (state == CONV_SHUNT);
   assign BUS_CONV_O = (state == CONV_BUS);
   assign BUS_RANGE_O = run_range;
   assign BUS_SETTING_O = run_bus_set;
   assign CONV_DONE_O = done;
   assign SHUNT_RESULT_O = shunt_result;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   a_soft_reset_defaults: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && soft_reset) |=> (cfg == `CFG_RESET) && (state == CONV_IDLE))
      else $error("soft reset did not restore defaults");

   a_reset_bit_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && cfg_write && !soft_reset) |=> (cfg[15] == 1'b0) && (cfg[14:0] == $past(write_word[14:0])))
      else $error("configuration write stored wrongly");

   a_read_msb_first: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && HOST_REQ_I.read_byte && !HOST_REQ_I.frame_start && !HOST_REQ_I.pointer_write
         && !HOST_REQ_I.data_write && msb_phase)
      |=> RD_VALID_O && (RD_BYTE_O == $past(read_word[15:8])) && !msb_phase)
      else $error("read did not return the high byte first");

   a_count_descends: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && state != CONV_IDLE && count != '0 && !soft_reset) |=> (count == $past(count) - 1'b1))
      else $error("conversion counter did not step down");

   a_gain_held: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (state == CONV_SHUNT && !conv_end && !soft_reset) |=> (run_gain == $past(run_gain)))
      else $error("gain changed during a shunt conversion");

   a_sign_bits_gain1: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && state == CONV_SHUNT && conv_end && run_gain == 2'h0 && !soft_reset)
      |=> (shunt_result[15:12] == {4{shunt_result[15]}}))
      else $error("shunt result sign bits differ at gain one");

   a_full_scale: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && state == CONV_SHUNT && conv_end && run_gain == 2'h3 && !soft_reset)
      |=> ($signed(shunt_result) <= $signed(`FS_GAIN8)) && ($signed(shunt_result) >= -$signed(`FS_GAIN8)))
      else $error("shunt result beyond full scale");

   a_trigger_once: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CE_I && done && !trig_pending && !cfg.mode[`CFG_MODE_CONT_BIT] && !cfg_write)
      |=> (state == CONV_IDLE) && !trig_pending)
      else $error("triggered mode converted again without a write");

endmodule

/* design/monitor_consts.svh */
// named constants for the monitor configuration and shunt result logic
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// register pointer addresses
`define CFG_ADDR 8'h00
`define SHUNT_ADDR 8'h01
// configuration reset value
`define CFG_RESET 16'h399F
// configuration field positions
`define CFG_SOFT_RESET_BIT 15
`define CFG_MODE_CONT_BIT 2
`define CFG_MODE_BUS_BIT 1
`define CFG_MODE_SHUNT_BIT 0
// converter setting fields
`define SET_AVG_BIT 3
`define SET_AVG_CODE_W 3
`define SET_RES_CODE_W 2
`define SET_AVG_BASE 4'h4
// clock period and conversion times in ns
`define CLK_PERIOD_NS 20
`define T_9BIT_NS 84000
`define T_10BIT_NS 148000
`define T_11BIT_NS 276000
`define T_12BIT_NS 532000
`define T_AVG2_NS 1060000
`define T_AVG4_NS 2130000
`define T_AVG8_NS 4260000
`define T_AVG16_NS 8510000
`define T_AVG32_NS 17020000
`define T_AVG64_NS 34050000
`define T_AVG128_NS 68100000
`define CONV_TIME_COUNT 12
// shunt full scale in 10 uV counts, gain codes 00..11
`define FS_GAIN1 16'h0FA0
`define FS_GAIN2 16'h1F40
`define FS_GAIN4 16'h3E80
`define FS_GAIN8 16'h7D00

`endif

/* design/monitor_pkg.sv */
// types shared by the monitor configuration and shunt result logic
package monitor_pkg;

   // configuration word layout, bit 15 down to bit 0
   typedef struct packed {
      logic soft_reset;
      logic spare;
      logic bus_range_select;
      logic [1:0] shunt_gain_select;
      logic [3:0] bus_conversion_setting;
      logic [3:0] shunt_conversion_setting;
      logic [2:0] mode;
   } measurement_configuration_s;

   // byte-level requests from the serial protocol engine
   typedef struct packed {
      logic frame_start;
      logic pointer_write;
      logic data_write;
      logic read_byte;
      logic [7:0] data;
   } host_request_s;

   // converter sequencing states
   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_SHUNT,
      CONV_BUS
   } conv_state_e;

endpackage

/* design/shunt_formatter.sv */
// clamps a raw shunt sample to the gain's full scale and forms the result word
`timescale 1ns/1ps
`include "monitor_consts.svh"

module shunt_formatter #(
   parameter int unsigned WIDTH = 16
) (
   input wire logic [1:0] shunt_gain_select_i,
   input wire logic signed [WIDTH-1:0] raw_sample_i,
   output logic [WIDTH-1:0] result_o
);

   logic signed [WIDTH-1:0] limit; // positive full scale for the gain

   // pick the full scale, then clamp; clamping keeps every sign bit equal
   always_comb begin
      case (shunt_gain_select_i)
         2'h0: limit = `FS_GAIN1;
         2'h1: limit = `FS_GAIN2;
         2'h2: limit = `FS_GAIN4;
         default: limit = `FS_GAIN8;
      endcase
      if (raw_sample_i > limit) begin
         result_o = limit;
      end else if (raw_sample_i < -limit) begin
         result_o = -limit;
      end else begin
         result_o = raw_sample_i;
      end
   end

endmodule

/* bench/host_byte_model.sv */
// byte-level host model: pointer writes, word writes and word reads
`timescale 1ns/1ps

module host_byte_model
   import monitor_pkg::*;
#(
   parameter int unsigned GAP = 200 // write to read-back spacing, 4 us at 20 ns
) (
   input wire logic clk_i,
   input wire logic [7:0] rd_byte_i,
   input wire logic rd_valid_i,
   output host_request_s req_o
);
   logic [7:0] last_ptr; // pointer of the last word written

   initial begin
      req_o = '0;
      last_ptr = 8'hFF;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one request held for one cycle; kind is frame, pointer, write, read
   task automatic pulse(input logic [3:0] kind, input logic [7:0] d, output logic [7:0] b);
      @(negedge clk_i);
      req_o = {kind, d};
      @(negedge clk_i);
      // released data no longer shows the last byte
      req_o = {4'h0, ~d};
      b = rd_valid_i ? rd_byte_i : 8'hXX;
   endtask

   // pointer byte, then high byte, then low byte
   task automatic write_word(input logic [7:0] ptr, input logic [15:0] wd);
      logic [7:0] b;
      pulse(4'h4, ptr, b);
      pulse(4'h2, wd[15:8], b);
      pulse(4'h2, wd[7:0], b);
      last_ptr = ptr;
   endtask

   // pointer byte, new frame, then two read bytes, high first
   task automatic read_word(input logic [7:0] ptr, output logic [15:0] wd);
      logic [7:0] b;
      if (ptr == last_ptr) begin
         repeat (GAP) @(negedge clk_i);
      end
      last_ptr = 8'hFF;
      pulse(4'h4, ptr, b);
      pulse(4'h8, 8'h00, b);
      pulse(4'h1, 8'h00, wd[15:8]);
      pulse(4'h1, 8'h00, wd[7:0]);
   endtask
endmodule

/* bench/monitor_config_and_shunt_result_tb.sv */
// self-checking bench for the monitor configuration and shunt result logic
`timescale 1ns/1ps

module monitor_config_and_shunt_result_tb;
   import monitor_pkg::*;

   localparam int unsigned CYC [12] = '{4, 5, 6, 7, 7, 8, 9, 10, 11, 12, 13, 14}; // short conversions
   localparam int SMP [8] = '{32002, 31999, 16001, -8001, -4001, 3999, -1, -32768}; // raw samples

   logic clk, rst, ce;
   host_request_s req;
   logic signed [15:0] sample;
   logic [7:0] rd_byte;
   logic rd_valid, shunt_conv, bus_conv, bus_range, conv_done;
   logic [3:0] bus_setting;
   logic [15:0] shunt_result, w;
   int n_mismatch = 0, comparisons = 0, cycles = 0, ns, nb, n;
   logic ps, pb;
   logic [2:0] snap; // conversion flags before the clock enable drops

   monitor_config_and_shunt_result #(.CONV_CYCLES(CYC)) dut (
      .SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .HOST_REQ_I(req), .SHUNT_SAMPLE_I(sample),
      .RD_BYTE_O(rd_byte), .RD_VALID_O(rd_valid), .SHUNT_CONV_O(shunt_conv), .BUS_CONV_O(bus_conv),
      .BUS_RANGE_O(bus_range), .BUS_SETTING_O(bus_setting), .CONV_DONE_O(conv_done),
      .SHUNT_RESULT_O(shunt_result));

   host_byte_model host (.clk_i(clk), .rd_byte_i(rd_byte), .rd_valid_i(rd_valid), .req_o(req));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial clk = 1'b0;
   always #10 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // waits for k end-of-sequence pulses, each within a bounded time
   task automatic wait_done(input int k);
      int t;
      repeat (k) begin
         t = 0;
         do begin
            @(negedge clk);
            t++;
         end while (conv_done !== 1'b1 && t < 300);
         chk("conversion done", 16'h1, {15'h0, conv_done});
      end
   endtask

   // length in cycles of the next shunt (sel 0) or bus (sel 1) conversion
   task automatic measure(input bit sel, output int len);
      int t;
      t = 0;
      len = 0;
      while ((sel ? bus_conv : shunt_conv) !== 1'b1 && t < 60) begin
         @(negedge clk);
         t++;
      end
      while ((sel ? bus_conv : shunt_conv) === 1'b1 && len < 100) begin
         @(negedge clk);
         len++;
      end
   endtask

   // table slot of a converter setting code
   function automatic int idx_of(input logic [3:0] c);
      return c[3] ? 4 + int'(c[2:0]) : int'(c[1:0]);
   endfunction

   // reading clamped to the gain's full scale, two's complement word
   function automatic logic [15:0] exp_shunt(input int s, input int g);
      int fs;
      fs = 4000 << g;
      if (s > fs) s = fs;
      if (s < -fs) s = -fs;
      return 16'(s);
   endfunction

   // continuous: 0 none, 1 repeating, 2 stopped after one
   function automatic int runs(input int cnt, input bit cont);
      return cont ? (cnt == 0 ? 0 : (cnt > 1 ? 1 : 2)) : cnt;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      sample = 16'sh0000;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("running after reset", 16'h1, {15'h0, shunt_conv});
      host.read_word(8'h00, w);
      chk("config reset", 16'h399F, w);
      chk("bus range", 16'h1, {15'h0, bus_range});
      chk("bus setting", 16'h3, {12'h0, bus_setting});
      $display("test reset done");
      // plain stored bit, 16 V range, discarded and unmapped places
      host.write_word(8'h00, 16'h4F3F);
      wait_done(2);
      chk("bus range", 16'h0, {15'h0, bus_range});
      chk("bus setting", 16'hE, {12'h0, bus_setting});
      host.write_word(8'h02, 16'hFFFF);
      host.write_word(8'h01, 16'hFFFF);
      host.read_word(8'h00, w);
      chk("config readback", 16'h4F3F, w);
      host.read_word(8'h01, w);
      chk("shunt read only", 16'h0000, w);
      host.read_word(8'h02, w);
      chk("unmapped read", 16'h0000, w);
      $display("test registers done");
      // every mode code
      for (int m = 0; m < 8; m++) begin
         host.write_word(8'h00, 16'h0000);
         repeat (40) @(negedge clk);
         host.write_word(8'h00, {13'h0, 3'(m)});
         ns = 0;
         nb = 0;
         ps = 1'b0;
         pb = 1'b0;
         repeat (100) begin
            @(negedge clk);
            ns += int'(shunt_conv & ~ps);
            nb += int'(bus_conv & ~pb);
            ps = shunt_conv;
            pb = bus_conv;
         end
         chk("shunt runs", 16'(m % 2), 16'(runs(ns, m >= 4)));
         chk("bus runs", 16'((m / 2) % 2), 16'(runs(nb, m >= 4)));
      end
      host.write_word(8'h00, 16'h0000);
      repeat (40) @(negedge clk);
      $display("test modes done");
      // every converter setting code, triggered
      for (int c = 0; c < 16; c++) begin
         host.write_word(8'h00, {9'h0, 4'(c), 3'h1});
         measure(1'b0, n);
         chk("shunt conversion length", 16'(CYC[idx_of(4'(c))]), 16'(n));
      end
      host.write_word(8'h00, {5'h0, 4'hF, 4'h0, 3'h2});
      measure(1'b1, n);
      chk("bus conversion length", 16'(CYC[11]), 16'(n));
      chk("bus setting", 16'hF, {12'h0, bus_setting});
      $display("test conversion times done");
      // result format at every gain
      for (int g = 0; g < 4; g++) begin
         host.write_word(8'h00, {3'h0, 2'(g), 8'h00, 3'h5});
         foreach (SMP[i]) begin
            sample = 16'(SMP[i]);
            wait_done(2);
            chk("shunt result", exp_shunt(SMP[i], g), shunt_result);
         end
         host.read_word(8'h01, w);
         chk("shunt result read", exp_shunt(SMP[7], g), w);
      end
      $display("test shunt format done");
      // soft reset, then a hard reset in mid-run
      host.write_word(8'h00, 16'hC000);
      chk("result cleared", 16'h0000, shunt_result);
      host.read_word(8'h00, w);
      chk("config after soft reset", 16'h399F, w);
      host.write_word(8'h00, 16'h0005);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("result after reset", 16'h0000, shunt_result);
      @(negedge clk);
      chk("running after second reset", 16'h1, {15'h0, shunt_conv});
      host.read_word(8'h00, w);
      chk("config after reset", 16'h399F, w);
      $display("test resets done");
      // clock enable low: nothing may move, then the run resumes
      snap = {shunt_conv, bus_conv, conv_done};
      ce = 1'b0;
      n = 0;
      repeat (30) begin
         @(negedge clk);
         n += int'({shunt_conv, bus_conv, conv_done} != snap);
      end
      ce = 1'b1;
      chk("changes while disabled", 16'h0, 16'(n));
      wait_done(1);
      $display("test clock enable done");
      end_of_test();
   end
endmodule
